// File: src/cpi_pkg.sv
// What this block does
// - One instruction per 300 ns cycle, ordered.
// - Bit position 7 is the least significant.
// - Field given by rightmost position and length.
// - Field read right-justified, zero filled.
// - Fixed 8-bit operands, unsigned 8-bit addition.
// - Goto decodes source, length, destination as one.
// - Pointers select input/output and scratch bytes.
// - Low external reset zeroes both fetch addresses.
// - Drive a copy of the system clock.
// - Counter holds next, address register holds current.
// - Seven general 8-bit working registers.
// - Carry bit captures addition carry, weight one.
// - Auxiliary register is implied second operand.
// - Address ranges select registers, vector, scratch.
// - Move copies source field into destination field.
// - Add, and, xor combine auxiliary with source.
// - Register to register: length rotates right.
// - Literal load writes immediate into source field.
// - Goto loads immediate into the address register, immediate plus one into the counter.
// - Branch when field nonzero, else continue.
// - Indexed execute runs one instruction, then resumes.
// - Offset base truncates to 32 or 256.
package cpi_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 5;
    localparam int CYCLE_NS       = 300;
    localparam int CYCLE_CLKS     = (CYCLE_NS / CLK_PERIOD_NS < 1) ? 1
                                    : CYCLE_NS / CLK_PERIOD_NS;
    localparam int MCLK_HIGH_CLKS = CYCLE_CLKS / 2;

    // ------------------------------------------------------------
    // Instruction word layout
    // ------------------------------------------------------------
    localparam int INSTR_W  = 16;
    localparam int OPC_MSB  = 15;
    localparam int OPC_LSB  = 13;
    localparam int SRC_MSB  = 12;
    localparam int SRC_LSB  = 8;
    localparam int LEN_MSB  = 7;
    localparam int LEN_LSB  = 5;
    localparam int DST_MSB  = 4;
    localparam int DST_LSB  = 0;
    localparam int GOTO_MSB = 12;

    // ------------------------------------------------------------
    // Address partitions and register addresses
    // ------------------------------------------------------------
    localparam logic [1:0] REGION_IO      = 2'h2;
    localparam logic [1:0] REGION_SCRATCH = 2'h3;
    localparam logic [4:0] ADDR_AUX       = 5'h00;
    localparam logic [4:0] ADDR_CARRY     = 5'h08;
    localparam logic [4:0] ADDR_IO_PTR    = 5'h09;
    localparam logic [4:0] ADDR_SCR_PTR   = 5'h0f;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  BYTE_RST  = 8'h00;
    localparam logic [11:0] FETCH_RST = 12'h000;

    // ------------------------------------------------------------
    // Operation codes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_MOVE              = 3'h0,
        OP_ADD               = 3'h1,
        OP_AND               = 3'h2,
        OP_XOR               = 3'h3,
        OP_LOAD_LITERAL      = 3'h4,
        OP_BRANCH_IF_NONZERO = 3'h5,
        OP_INDEXED_EXECUTE   = 3'h6,
        OP_GOTO              = 3'h7
    } cpi_op_t;

endpackage

// File: src/cpi_field_unit.sv
`timescale 1ns/1ps
module cpi_field_unit (
    // Source byte and field.
    input  wire logic [7:0] srcByte,
    input  wire logic [2:0] srcPos,
    input  wire logic [2:0] lenCode,
    // Destination byte and field.
    input  wire logic [7:0] dstByte,
    input  wire logic [2:0] dstPos,
    input  wire logic [7:0] wrValue,
    // Results.
    output logic      [7:0] fieldValue,
    output logic      [7:0] mergedByte
);
    logic [3:0] lenEff;
    logic [7:0] lowMask;
    logic [7:0] dstMask;

    // ------------------------------------------------------------
    // Field mask
    // ------------------------------------------------------------
    assign lenEff = (lenCode == 3'h0) ? 4'h8 : {1'b0, lenCode};

    for (genvar i = 0; i < 8; i++) begin : g_mask
        assign lowMask[i] = (4'(i) < lenEff);
    end

    // ------------------------------------------------------------
    // Extract and merge
    // ------------------------------------------------------------
    // Position p sits at vector bit 7-p, so the shift is the inverted position.
    assign fieldValue = (srcByte >> ~srcPos) & lowMask;
    assign dstMask    = lowMask << ~dstPos;
    assign mergedByte = (dstByte & ~dstMask) | ((wrValue << ~dstPos) & dstMask);

endmodule

// File: src/cpi_interpreter.sv
`timescale 1ns/1ps
module cpi_interpreter #(
    parameter int PROG_AW = 12
) (
    // Clock and resets.
    input  wire logic                clock,
    input  wire logic                rst,
    input  wire logic                extResetN,
    // Clock mirror.
    output logic                     mclkOut,
    // Program storage.
    output logic [PROG_AW-1:0]       progAddr,
    input  wire logic [cpi_pkg::INSTR_W-1:0] progData,
    // Input/output vector byte.
    output logic [7:0]               ioAddr,
    input  wire logic [7:0]          ioRdData,
    output logic [7:0]               ioWrData,
    output logic                     ioWrEn,
    // Scratch storage byte.
    output logic [7:0]               scrAddr,
    input  wire logic [7:0]          scrRdData,
    output logic [7:0]               scrWrData,
    output logic                     scrWrEn,
    // Status.
    output logic [PROG_AW-1:0]       nextFetch,
    output logic                     carryBit
);
    import cpi_pkg::*;

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (PROG_AW < 9 || PROG_AW > 12) begin : g_bad_width
        $error("PROG_AW must lie between 9 and 12.");
    end

    localparam int CNT_W = $clog2(CYCLE_CLKS + 1);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [CNT_W-1:0]   divCntQ;
    logic               mclkQ;
    logic [PROG_AW-1:0] fetchAddrQ;
    logic [PROG_AW-1:0] nextFetchQ;
    logic [7:0]         auxQ;
    logic [7:0]         wrQ [1:7];
    logic               carryQ;
    logic [7:0]         ioPtrQ;
    logic [7:0]         scrPtrQ;
    logic               ioWrEnQ;
    logic [7:0]         ioWrDataQ;
    logic               scrWrEnQ;
    logic [7:0]         scrWrDataQ;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    cpi_op_t            op;
    logic [4:0]         srcA;
    logic [2:0]         lenCode;
    logic [4:0]         dstA;
    logic               stepEn;
    logic               srcIsReg;
    logic               srcIsIo;
    logic               dstIsReg;
    logic [4:0]         tgtA;
    logic               tgtIsReg;
    logic               tgtIsIo;
    logic               writesData;
    logic [7:0]         literal;
    logic [7:0]         srcRegVal;
    logic [7:0]         srcByte;
    logic [7:0]         fieldVal;
    logic [7:0]         srcVal;
    logic [7:0]         rotated;
    logic [7:0]         operandB;
    logic [8:0]         sum;
    logic               addCarry;
    logic [7:0]         aluOut;
    logic [7:0]         dstByte;
    logic [7:0]         mergedByte;
    logic [PROG_AW-1:0] offsetBase;
    logic [7:0]         offset;
    logic [PROG_AW-1:0] branchTgt;
    logic [PROG_AW-1:0] gotoTgt;
    logic [PROG_AW-1:0] fetchAddrD;
    logic [PROG_AW-1:0] nextFetchD;

    assign stepEn  = extResetN && (divCntQ == CNT_W'(CYCLE_CLKS - 1));
    assign op      = cpi_op_t'(progData[OPC_MSB:OPC_LSB]);
    assign srcA    = progData[SRC_MSB:SRC_LSB];
    assign lenCode = progData[LEN_MSB:LEN_LSB];
    assign dstA    = progData[DST_MSB:DST_LSB];

    // Octal 00-17 registers, 20-27 vector byte, 30-37 scratch byte.
    assign srcIsReg = !srcA[4];
    assign srcIsIo  = (srcA[4:3] == REGION_IO);
    assign dstIsReg = !dstA[4];

    // The literal load writes into the field named by the source address.
    assign tgtA       = (op == OP_LOAD_LITERAL) ? srcA : dstA;
    assign tgtIsReg   = !tgtA[4];
    assign tgtIsIo    = (tgtA[4:3] == REGION_IO);
    assign writesData = (op <= OP_LOAD_LITERAL);

    // Field addresses limit the literal to five bits, registers allow eight.
    assign literal = srcIsReg ? {lenCode, dstA} : {3'h0, dstA};

    // ------------------------------------------------------------
    // Read source
    // ------------------------------------------------------------
    always_comb begin
        srcRegVal = BYTE_RST;
        if (srcA == ADDR_AUX) begin
            srcRegVal = auxQ;
        end else if (srcA[4:3] == 2'h0) begin
            srcRegVal = wrQ[srcA[2:0]];
        end else if (srcA == ADDR_CARRY) begin
            srcRegVal = {7'h00, carryQ};
        end else if (srcA == ADDR_IO_PTR) begin
            srcRegVal = ioPtrQ;
        end else if (srcA == ADDR_SCR_PTR) begin
            srcRegVal = scrPtrQ;
        end
    end

    assign srcByte = srcIsReg ? srcRegVal : (srcIsIo ? ioRdData : scrRdData);
    assign dstByte = tgtIsIo ? ioRdData : scrRdData;

    cpi_field_unit u_field (
        .srcByte    (srcByte),
        .srcPos     (srcA[2:0]),
        .lenCode    (lenCode),
        .dstByte    (dstByte),
        .dstPos     (tgtA[2:0]),
        .wrValue    (aluOut),
        .fieldValue (fieldVal),
        .mergedByte (mergedByte)
    );

    assign srcVal   = srcIsReg ? srcRegVal : fieldVal;
    assign rotated  = (srcRegVal >> lenCode) | (srcRegVal << (4'h8 - {1'b0, lenCode}));
    assign operandB = (srcIsReg && dstIsReg) ? rotated : srcVal;

    // ------------------------------------------------------------
    // Operate
    // ------------------------------------------------------------
    assign sum      = {1'b0, auxQ} + {1'b0, operandB};
    assign addCarry = sum[8];

    always_comb begin
        aluOut = operandB;
        unique case (op)
            OP_ADD:          aluOut = sum[7:0];
            OP_AND:          aluOut = auxQ & operandB;
            OP_XOR:          aluOut = auxQ ^ operandB;
            OP_LOAD_LITERAL: aluOut = literal;
            default:         aluOut = operandB;
        endcase
    end

    // ------------------------------------------------------------
    // Next program word
    // ------------------------------------------------------------
    assign offsetBase = srcIsReg ? {nextFetchQ[PROG_AW-1:8], 8'h00}
                                 : {nextFetchQ[PROG_AW-1:5], 5'h00};
    assign offset     = (op == OP_INDEXED_EXECUTE) ? literal + srcVal : literal;
    assign branchTgt  = offsetBase + PROG_AW'(offset);
    assign gotoTgt    = PROG_AW'(progData[GOTO_MSB:0]);

    always_comb begin
        fetchAddrD = nextFetchQ;
        nextFetchD = nextFetchQ + PROG_AW'(1);
        unique case (op)
            OP_GOTO: begin
                fetchAddrD = gotoTgt;
                nextFetchD = gotoTgt + PROG_AW'(1);
            end
            OP_BRANCH_IF_NONZERO: begin
                if (srcVal != 8'h00) begin
                    fetchAddrD = branchTgt;
                    nextFetchD = branchTgt + PROG_AW'(1);
                end
            end
            OP_INDEXED_EXECUTE: begin
                fetchAddrD = branchTgt;
                nextFetchD = nextFetchQ;
            end
            default: begin
                fetchAddrD = nextFetchQ;
                nextFetchD = nextFetchQ + PROG_AW'(1);
            end
        endcase
    end

    // ------------------------------------------------------------
    // Cycle divider and clock mirror
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst || !extResetN) begin
            divCntQ <= '0;
            mclkQ   <= 1'b1;
        end else if (stepEn) begin
            divCntQ <= '0;
            mclkQ   <= 1'b1;
        end else begin
            divCntQ <= divCntQ + CNT_W'(1);
            mclkQ   <= (divCntQ + CNT_W'(1)) < CNT_W'(MCLK_HIGH_CLKS);
        end
    end

    // ------------------------------------------------------------
    // Fetch addresses
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst || !extResetN) begin
            fetchAddrQ <= FETCH_RST[PROG_AW-1:0];
            nextFetchQ <= FETCH_RST[PROG_AW-1:0];
        end else if (stepEn) begin
            fetchAddrQ <= fetchAddrD;
            nextFetchQ <= nextFetchD;
        end
    end

    // ------------------------------------------------------------
    // Internal registers
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            auxQ    <= BYTE_RST;
            ioPtrQ  <= BYTE_RST;
            scrPtrQ <= BYTE_RST;
        end else if (stepEn && writesData && tgtIsReg) begin
            if (tgtA == ADDR_AUX) begin
                auxQ <= aluOut;
            end
            if (tgtA == ADDR_IO_PTR) begin
                ioPtrQ <= aluOut;
            end
            if (tgtA == ADDR_SCR_PTR) begin
                scrPtrQ <= aluOut;
            end
        end
    end

    for (genvar r = 1; r <= 7; r++) begin : g_work
        always_ff @(posedge clock) begin
            if (rst) begin
                wrQ[r] <= BYTE_RST;
            end else if (stepEn && writesData && tgtA == 5'(r)) begin
                wrQ[r] <= aluOut;
            end
        end
    end

    // An addition always owns the carry bit, even when it also names it.
    always_ff @(posedge clock) begin
        if (rst) begin
            carryQ <= 1'b0;
        end else if (stepEn && op == OP_ADD) begin
            carryQ <= addCarry;
        end else if (stepEn && writesData && tgtA == ADDR_CARRY) begin
            carryQ <= aluOut[0];
        end
    end

    // ------------------------------------------------------------
    // Field writes to vector and scratch bytes
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            ioWrEnQ    <= 1'b0;
            ioWrDataQ  <= BYTE_RST;
            scrWrEnQ   <= 1'b0;
            scrWrDataQ <= BYTE_RST;
        end else begin
            ioWrEnQ  <= stepEn && writesData && tgtIsIo;
            scrWrEnQ <= stepEn && writesData && !tgtIsReg && !tgtIsIo;
            if (stepEn) begin
                ioWrDataQ  <= mergedByte;
                scrWrDataQ <= mergedByte;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign mclkOut   = mclkQ;
    assign progAddr  = fetchAddrQ;
    assign nextFetch = nextFetchQ;
    assign ioAddr    = ioPtrQ;
    assign scrAddr   = scrPtrQ;
    assign ioWrData  = ioWrDataQ;
    assign ioWrEn    = ioWrEnQ;
    assign scrWrData = scrWrDataQ;
    assign scrWrEn   = scrWrEnQ;
    assign carryBit  = carryQ;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    step_spacing_a: assert property (stepEn |=> (!stepEn)[*8])
        else $error("Instruction steps closer than one cycle period.");

    ext_reset_zero_a: assert property (!extResetN |=> progAddr == '0 && nextFetch == '0)
        else $error("Fetch addresses not zero under external reset.");

    mclk_follow_a: assert property (stepEn |=> mclkOut [*8])
        else $error("Clock mirror not high at the start of a cycle.");

    seq_advance_a: assert property (stepEn && op <= OP_LOAD_LITERAL |=>
        progAddr == $past(nextFetch) && nextFetch == $past(nextFetch) + PROG_AW'(1))
        else $error("Sequential instruction did not advance by one.");

    goto_target_a: assert property (stepEn && op == OP_GOTO |=> progAddr == $past(gotoTgt))
        else $error("Goto did not load its immediate target.");

    exec_resume_a: assert property (stepEn && op == OP_INDEXED_EXECUTE |=>
        nextFetch == $past(nextFetch) && progAddr == $past(branchTgt))
        else $error("Indexed execute lost its resume address.");

    nz_fallthrough_a: assert property (stepEn && op == OP_BRANCH_IF_NONZERO && srcVal == 8'h00
        |=> progAddr == $past(nextFetch))
        else $error("Zero field did not continue in sequence.");

    carry_capture_a: assert property (stepEn && op == OP_ADD |=> carryBit == $past(addCarry))
        else $error("Carry bit missed the addition carry.");

    io_write_a: assert property (stepEn && writesData && tgtIsIo |=>
        ioWrEn && ioWrData == $past(mergedByte) ##1 !ioWrEn)
        else $error("Vector field write not a single merged pulse.");

    cover_goto: cover property (stepEn && op == OP_GOTO);
    cover_exec: cover property (stepEn && op == OP_INDEXED_EXECUTE);
    cover_branch: cover property (stepEn && op == OP_BRANCH_IF_NONZERO && srcVal != 8'h00);
    cover_carry: cover property (stepEn && op == OP_ADD && addCarry);

endmodule

// File: sim/cpi_mem_model.sv
`timescale 1ns/1ps
module cpi_mem_model (
    // Clock.
    input  wire logic        clock,
    // Program storage.
    input  wire logic [11:0] progAddr,
    output logic      [15:0] progData,
    // Vector bytes.
    input  wire logic [7:0]  ioAddr,
    output logic      [7:0]  ioRdData,
    input  wire logic [7:0]  ioWrData,
    input  wire logic        ioWrEn,
    // Scratch bytes.
    input  wire logic [7:0]  scrAddr,
    output logic      [7:0]  scrRdData,
    input  wire logic [7:0]  scrWrData,
    input  wire logic        scrWrEn
);
    logic [15:0] prog [0:4095];
    logic [7:0]  io   [0:255];
    logic [7:0]  scr  [0:255];

    // ------------------------------------------------------------
    // Reads and writes go to the byte picked by each pointer.
    // ------------------------------------------------------------
    assign progData  = prog[progAddr];
    assign ioRdData  = io[ioAddr];
    assign scrRdData = scr[scrAddr];

    always @(posedge clock) begin
        if (ioWrEn) begin
            io[ioAddr] <= ioWrData;
        end
        if (scrWrEn) begin
            scr[scrAddr] <= scrWrData;
        end
    end
endmodule

// File: sim/control_processor_interpreter_tb_top.sv
`timescale 1ns/1ps
module control_processor_interpreter_tb_top;
    import cpi_pkg::*;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        extResetN = 1'b1;
    logic        mclkOut, ioWrEn, scrWrEn, carryBit;
    logic [11:0] progAddr, nextFetch;
    logic [15:0] progData;
    logic [7:0]  ioAddr, ioRdData, ioWrData, scrAddr, scrRdData, scrWrData;
    logic [16:0] wrLog [$];
    logic [16:0] expLog [7] = '{17'h00510, 17'h00518, 17'h100ac, 17'h0052f,
                               17'h00520, 17'h00510, 17'h103b1};
    int          n_fail = 0;
    int          checks_done = 0;
    int          cycles = 0;
    int          highs;

    always #2.5 clock = ~clock;

    cpi_interpreter #(.PROG_AW(12)) i_dut (
        .clock(clock), .rst(rst), .extResetN(extResetN), .mclkOut(mclkOut),
        .progAddr(progAddr), .progData(progData), .ioAddr(ioAddr),
        .ioRdData(ioRdData), .ioWrData(ioWrData), .ioWrEn(ioWrEn),
        .scrAddr(scrAddr), .scrRdData(scrRdData), .scrWrData(scrWrData),
        .scrWrEn(scrWrEn), .nextFetch(nextFetch), .carryBit(carryBit)
    );

    cpi_mem_model i_mem (
        .clock(clock), .progAddr(progAddr), .progData(progData),
        .ioAddr(ioAddr), .ioRdData(ioRdData), .ioWrData(ioWrData), .ioWrEn(ioWrEn),
        .scrAddr(scrAddr), .scrRdData(scrRdData), .scrWrData(scrWrData),
        .scrWrEn(scrWrEn)
    );

    // ------------------------------------------------------------
    // Helpers.
    // ------------------------------------------------------------
    function automatic logic [15:0] ins(input logic [2:0] op, input logic [4:0] s,
                                        input logic [2:0] l, input logic [4:0] d);
        return {op, s, l, d};
    endfunction

    task automatic chk(input string name, input logic [16:0] expV, input logic [16:0] got);
        checks_done++;
        if (got !== expV) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", name, expV, got);
        end
    endtask

    task automatic complete_run;
        $display("Checks made: %0d, mismatches: %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        if (ioWrEn) begin
            wrLog.push_back({1'b0, ioAddr, ioWrData});
        end
        if (scrWrEn) begin
            wrLog.push_back({1'b1, scrAddr, scrWrData});
        end
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            complete_run();
        end
    end

    // ------------------------------------------------------------
    // Program with field, rotate, branch and indexed execution.
    // ------------------------------------------------------------
    initial begin
        #1;
        for (int i = 0; i < 4096; i++) begin
            i_mem.prog[i] = 16'h0000;
        end
        for (int i = 0; i < 256; i++) begin
            i_mem.io[i] = 8'h00;
            i_mem.scr[i] = 8'h00;
        end
        i_mem.scr[0] = 8'ha8;
        i_mem.scr[3] = 8'h81;
        i_mem.prog[0]  = ins(3'h4, 5'h09, 3'h0, 5'h05);
        i_mem.prog[1]  = ins(3'h4, 5'h01, 3'h7, 5'h10);
        i_mem.prog[2]  = ins(3'h4, 5'h00, 3'h1, 5'h00);
        i_mem.prog[3]  = ins(3'h1, 5'h01, 3'h0, 5'h02);
        i_mem.prog[4]  = ins(3'h0, 5'h02, 3'h0, 5'h17);
        i_mem.prog[5]  = ins(3'h0, 5'h08, 3'h1, 5'h14);
        i_mem.prog[6]  = ins(3'h0, 5'h16, 3'h3, 5'h1f);
        i_mem.prog[7]  = ins(3'h0, 5'h01, 3'h4, 5'h04);
        i_mem.prog[8]  = ins(3'h3, 5'h04, 3'h0, 5'h17);
        i_mem.prog[9]  = ins(3'h2, 5'h01, 3'h0, 5'h17);
        i_mem.prog[10] = ins(3'h5, 5'h08, 3'h0, 5'h10);
        i_mem.prog[11] = ins(3'h0, 5'h00, 3'h0, 5'h17);
        i_mem.prog[16] = ins(3'h6, 5'h12, 3'h1, 5'h03);
        i_mem.prog[17] = ins(3'h5, 5'h0a, 3'h0, 5'h1f);
        i_mem.prog[18] = ins(3'h4, 5'h0f, 3'h0, 5'h03);
        i_mem.prog[19] = ins(3'h4, 5'h1b, 3'h2, 5'h03);
        i_mem.prog[20] = ins(3'h7, 5'h00, 3'h0, 5'h14);
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        repeat (59) @(posedge clock);
        #1 chk("progAddr before first step", 17'h0, progAddr);
        chk("nextFetch before first step", 17'h0, nextFetch);
        @(posedge clock);
        #1 chk("progAddr after first step", 17'h0, progAddr);
        chk("nextFetch after first step", 17'h1, nextFetch);
        highs = 0;
        repeat (60) @(posedge clock) highs += (mclkOut === 1'b1);
        chk("clock mirror high count", 17'd30, highs[16:0]);
        for (int i = 0; i < 40 && progAddr !== 12'd20; i++) repeat (60) @(posedge clock);
        repeat (3) @(posedge clock);
        #1 chk("halt address", 17'd20, progAddr);
        chk("carry bit", 17'h1, {16'h0000, carryBit});
        chk("write count", 17'd7, 17'(wrLog.size()));
        for (int i = 0; i < 7; i++) chk("write entry", expLog[i], wrLog[i]);
        @(posedge clock);
        extResetN <= 1'b0;
        repeat (3) @(posedge clock);
        #1 chk("progAddr in reset", 17'h0, progAddr);
        chk("nextFetch in reset", 17'h0, nextFetch);
        @(posedge clock);
        extResetN <= 1'b1;
        repeat (59) @(posedge clock);
        #1 chk("nextFetch before restart step", 17'h0, nextFetch);
        @(posedge clock);
        #1 chk("progAddr after restart", 17'h0, progAddr);
        chk("nextFetch after restart", 17'h1, nextFetch);
        complete_run();
    end
endmodule
